// file: rtl/nsv_pkg.sv
package nsv_pkg;
	// Register bus geometry
	localparam int AXI_AW = 8;
	localparam int AXI_DW = 32;
	localparam logic [7:0] ADDR_WORD_MASK = 8'hFC;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Register byte offsets
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_INDEX = 8'h04;
	localparam logic [7:0] OFS_CMD_HI = 8'h08;
	localparam logic [7:0] OFS_CMD_LO = 8'h0C;
	localparam logic [7:0] OFS_SECURITY = 8'h10;
	localparam logic [7:0] OFS_MARGIN = 8'h14;
	// Status register layout and reset value
	localparam int B_DONE = 7;
	localparam int B_ACC_ERR = 5;
	localparam int B_PROT_VIOL = 4;
	localparam int B_MG1 = 1;
	localparam int B_MG0 = 0;
	localparam logic [7:0] STATUS_RST = 8'h80;
	// Security and margin register layout
	localparam int B_SECURED = 0;
	localparam int B_LOCKED = 1;
	localparam int B_KEY_EN = 6;
	localparam int B_EE_MG = 2;
	// Command opcodes and launch indices
	localparam logic [7:0] OP_KEY_CHECK = 8'h0C;
	localparam logic [7:0] OP_SET_MARGIN = 8'h0D;
	localparam logic [7:0] OP_BLANK_CHECK = 8'h10;
	localparam logic [2:0] IX_KEY_LAST = 3'h4;
	localparam logic [2:0] IX_PARAM = 3'h2;
	localparam int CBUF_DEPTH = 8;
	// Backdoor key enable code; key 0 sits at this config word
	localparam logic [1:0] KEY_EN_ON = 2'h2;
	localparam logic [15:0] KEY0_WORD_ADDR = 16'hFF70;
	// Margin level codes
	localparam logic [15:0] MG_NORMAL = 16'h0000;
	localparam logic [15:0] MG_ERASED = 16'h0001;
	localparam logic [15:0] MG_PROGRAMMED = 16'h0002;
	// Global address map of the two blocks
	localparam int B_BLOCK_SEL = 23;
	localparam logic [23:0] FL_END = 24'h003FFF;
	localparam logic [23:0] EE_BASE = 24'h800000;
	localparam logic [23:0] EE_END = 24'h8000FF;
	localparam logic [24:0] EE_LIMIT = 25'h0800100;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	// Command engine states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CHECK = 2'b01,
		ST_BLANK = 2'b10
	} nsv_state_t;
endpackage

// file: rtl/nsv_top.sv
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module nsv_top (
	// Clock, reset, enable
	input wire logic CORE_CLK_IN,
	input wire logic RSTN_IN,
	input wire logic CE_IN,
	// AXI4-Lite write channels
	input wire logic [nsv_pkg::AXI_AW-1:0] S_AXI_AWADDR_IN,
	input wire logic S_AXI_AWVALID_IN,
	output logic S_AXI_AWREADY_OUT,
	input wire logic [nsv_pkg::AXI_DW-1:0] S_AXI_WDATA_IN,
	input wire logic [3:0] S_AXI_WSTRB_IN,
	input wire logic S_AXI_WVALID_IN,
	output logic S_AXI_WREADY_OUT,
	output logic [1:0] S_AXI_BRESP_OUT,
	output logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	// AXI4-Lite read channels
	input wire logic [nsv_pkg::AXI_AW-1:0] S_AXI_ARADDR_IN,
	input wire logic S_AXI_ARVALID_IN,
	output logic S_AXI_ARREADY_OUT,
	output logic [nsv_pkg::AXI_DW-1:0] S_AXI_RDATA_OUT,
	output logic [1:0] S_AXI_RRESP_OUT,
	output logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN,
	// Configuration field and mode
	input wire logic [1:0] KEY_EN_IN,
	input wire logic [63:0] BACKDOOR_KEYS_IN,
	input wire logic CMD_MODE_OK_IN,
	// EEPROM array read port
	output logic EE_RD_REQ_OUT,
	output logic [23:0] EE_RD_ADDR_OUT,
	input wire logic EE_RD_ACK_IN,
	input wire logic [7:0] EE_RD_DATA_IN,
	input wire logic EE_RD_ERR_IN,
	input wire logic EE_RD_FATAL_IN,
	// Security and read margin state
	output logic SECURE_OUT,
	output logic [1:0] FLASH_MARGIN_OUT,
	output logic [1:0] EE_MARGIN_OUT
);
	import nsv_pkg::*;

	// Whole module state in one record
	typedef struct packed {
		nsv_state_t st;
		logic [7:0] stat; // Status flags
		logic [2:0] cix; // Command object index
		logic [CBUF_DEPTH-1:0][15:0] cbuf; // Command object buffer
		logic secured; // Security engaged
		logic locked; // Key check lockout
		logic [1:0] fl_mg; // Flash margin level
		logic [1:0] ee_mg; // EEPROM margin level
		logic [23:0] cur; // Blank check address
		logic [15:0] left; // Bytes still to check
		logic rd_req; // Array read request
		logic aw_got; // Write address held
		logic [7:0] aw_addr;
		logic w_got; // Write data held
		logic [31:0] wdata;
		logic wlane0; // Low byte lane strobed
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} nsv_regs_t;

	nsv_regs_t s_r;
	nsv_regs_t s_nxt;

	// Decoded command fields
	logic [7:0] opcode;
	logic [23:0] gaddr;
	logic [15:0] param;
	logic is_ee; // Address names the EEPROM block
	logic addr_ok; // Address lands inside its block
	logic key_gate_ok; // Index, enable and lockout fine
	logic key_match;
	logic mg_code_ok;
	logic mg_ok; // Margin command fully valid
	logic range_ok;
	logic blank_ok; // Blank check fully valid
	logic [24:0] range_end;
	logic launch; // Software starts a command
	logic [7:0] wr_ofs;
	logic [7:0] rd_ofs;
	logic [7:0] rd_byte;
	logic rd_hit;

	// Command fields come straight from the buffer slots
	assign opcode = s_r.cbuf[0][15:8];
	assign gaddr = {s_r.cbuf[0][7:0], s_r.cbuf[1]};
	assign param = s_r.cbuf[IX_PARAM];
	assign is_ee = gaddr[B_BLOCK_SEL];
	assign wr_ofs = s_r.aw_addr & ADDR_WORD_MASK;
	assign rd_ofs = S_AXI_ARADDR_IN & ADDR_WORD_MASK;

	// Address check against the block the top bit selects
	always_comb begin
		if (is_ee) begin
			addr_ok = (gaddr >= EE_BASE) && (gaddr <= EE_END);
		end else begin
			addr_ok = (gaddr <= FL_END);
		end
	end

	// Key check qualification; slot 1 meets the key at the highest word
	assign key_gate_ok = (s_r.cix == IX_KEY_LAST)
		&& (KEY_EN_IN == KEY_EN_ON)
		&& !s_r.locked;
	assign key_match = {s_r.cbuf[1], s_r.cbuf[2], s_r.cbuf[3], s_r.cbuf[4]}
		== BACKDOOR_KEYS_IN;

	// Margin command qualification
	assign mg_code_ok = (param == MG_NORMAL) || (param == MG_ERASED)
		|| (param == MG_PROGRAMMED);
	assign mg_ok = mg_code_ok && addr_ok
		&& (s_r.cix == IX_PARAM)
		&& CMD_MODE_OK_IN;

	// Blank check range must stop at the last EEPROM byte
	assign range_end = {1'b0, gaddr} + {9'h000, param};
	assign range_ok = (range_end <= EE_LIMIT);
	assign blank_ok = is_ee && addr_ok && range_ok
		&& (s_r.cix == IX_PARAM)
		&& CMD_MODE_OK_IN;

	// A launch is a one written to the complete flag while it is set
	assign launch = s_r.aw_got && s_r.w_got && !s_r.bvalid && s_r.wlane0
		&& (wr_ofs == OFS_STATUS) && s_r.wdata[B_DONE]
		&& s_r.stat[B_DONE];

	// Read data multiplexer, sampled into the read channel register
	always_comb begin
		rd_byte = 8'h00;
		rd_hit = 1'b1;
		case (rd_ofs)
			OFS_STATUS: begin
				rd_byte = s_r.stat;
			end
			OFS_INDEX: begin
				rd_byte = {5'h00, s_r.cix};
			end
			OFS_CMD_HI: begin
				rd_byte = s_r.cbuf[s_r.cix][15:8];
			end
			OFS_CMD_LO: begin
				rd_byte = s_r.cbuf[s_r.cix][7:0];
			end
			OFS_SECURITY: begin
				rd_byte[B_SECURED] = s_r.secured;
				rd_byte[B_LOCKED] = s_r.locked;
				rd_byte[B_KEY_EN+1:B_KEY_EN] = KEY_EN_IN;
			end
			OFS_MARGIN: begin
				rd_byte[B_EE_MG+1:B_EE_MG] = s_r.ee_mg;
				rd_byte[1:0] = s_r.fl_mg;
			end
			default: begin
				rd_hit = 1'b0; // Unmapped word
			end
		endcase
	end

	// Next state: bus slave first, engine last so its sets win
	always_comb begin
		s_nxt = s_r;
		// Address and data are taken in either order
		if (!s_r.aw_got && S_AXI_AWVALID_IN) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.aw_addr = S_AXI_AWADDR_IN;
		end
		if (!s_r.w_got && S_AXI_WVALID_IN) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = S_AXI_WDATA_IN;
			s_nxt.wlane0 = S_AXI_WSTRB_IN[0];
		end
		// Register write once both halves are in
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = RESP_OKAY;
			case (wr_ofs)
				OFS_STATUS: begin
					if (s_r.wlane0) begin
						// Write one to clear the access error and violation flags
						if (s_r.wdata[B_ACC_ERR]) begin
							s_nxt.stat[B_ACC_ERR] = 1'b0;
						end
						if (s_r.wdata[B_PROT_VIOL]) begin
							s_nxt.stat[B_PROT_VIOL] = 1'b0;
						end
						if (launch) begin
							s_nxt.stat[B_DONE] = 1'b0;
							s_nxt.stat[B_MG1] = 1'b0;
							s_nxt.stat[B_MG0] = 1'b0;
							s_nxt.st = ST_CHECK;
						end
					end
				end
				// Buffer and index are frozen while a command runs
				OFS_INDEX: begin
					if (s_r.wlane0 && s_r.stat[B_DONE]) begin
						s_nxt.cix = s_r.wdata[2:0];
					end
				end
				OFS_CMD_HI: begin
					if (s_r.wlane0 && s_r.stat[B_DONE]) begin
						s_nxt.cbuf[s_r.cix][15:8] = s_r.wdata[7:0];
					end
				end
				OFS_CMD_LO: begin
					if (s_r.wlane0 && s_r.stat[B_DONE]) begin
						s_nxt.cbuf[s_r.cix][7:0] = s_r.wdata[7:0];
					end
				end
				OFS_SECURITY, OFS_MARGIN: begin
					s_nxt.bresp = RESP_OKAY; // Read only, write ignored
				end
				default: begin
					s_nxt.bresp = RESP_SLVERR;
				end
			endcase
		end
		if (s_r.bvalid && S_AXI_BREADY_IN) begin
			s_nxt.bvalid = 1'b0;
		end
		// Read: one cycle from address to data
		if (S_AXI_ARVALID_IN && !s_r.rvalid) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = AXI_DW'(rd_byte);
			s_nxt.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (s_r.rvalid && S_AXI_RREADY_IN) begin
			s_nxt.rvalid = 1'b0;
		end
		// Command engine; the violation flag is never touched here
		case (s_r.st)
			ST_IDLE: begin
				s_nxt.rd_req = 1'b0;
			end
			ST_CHECK: begin
				s_nxt.st = ST_IDLE;
				s_nxt.stat[B_DONE] = 1'b1;
				case (opcode)
					OP_KEY_CHECK: begin
						if (!key_gate_ok) begin
							s_nxt.stat[B_ACC_ERR] = 1'b1;
						end else if (key_match) begin
							s_nxt.secured = 1'b0;
						end else begin
							s_nxt.stat[B_ACC_ERR] = 1'b1;
							s_nxt.locked = 1'b1;
						end
					end
					OP_SET_MARGIN: begin
						if (!mg_ok) begin
							s_nxt.stat[B_ACC_ERR] = 1'b1;
						end else if (is_ee) begin
							s_nxt.ee_mg = param[1:0];
						end else begin
							s_nxt.fl_mg = param[1:0];
							s_nxt.ee_mg = param[1:0];
						end
					end
					OP_BLANK_CHECK: begin
						if (!blank_ok) begin
							s_nxt.stat[B_ACC_ERR] = 1'b1;
						end else if (param != 16'h0000) begin
							// Zero bytes passes at once
							s_nxt.stat[B_DONE] = 1'b0;
							s_nxt.st = ST_BLANK;
							s_nxt.cur = gaddr;
							s_nxt.left = param;
							s_nxt.rd_req = 1'b1;
						end
					end
					default: begin
						s_nxt.stat[B_ACC_ERR] = 1'b1; // Unknown opcode
					end
				endcase
			end
			ST_BLANK: begin
				// Request stays up; each ack delivers one byte
				if (EE_RD_ACK_IN) begin
					if (EE_RD_DATA_IN != ERASED_BYTE) begin
						s_nxt.stat[B_MG1] = 1'b1;
						s_nxt.stat[B_MG0] = 1'b1;
					end
					if (EE_RD_ERR_IN || EE_RD_FATAL_IN) begin
						s_nxt.stat[B_MG1] = 1'b1;
					end
					if (EE_RD_FATAL_IN) begin
						s_nxt.stat[B_MG0] = 1'b1;
					end
					s_nxt.cur = s_r.cur + 24'h000001;
					s_nxt.left = s_r.left - 16'h0001;
					if (s_r.left == 16'h0001) begin
						s_nxt.rd_req = 1'b0;
						s_nxt.st = ST_IDLE;
						s_nxt.stat[B_DONE] = 1'b1;
					end
				end
			end
			default: begin
				s_nxt.st = ST_IDLE; // Recover from an illegal code
			end
		endcase
	end

	// State register; enable low freezes everything
	always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			s_r <= '0;
			s_r.st <= ST_IDLE;
			s_r.stat <= STATUS_RST;
			s_r.secured <= 1'b1; // Secure until keys match
		end else if (CE_IN) begin
			s_r <= s_nxt;
		end
	end

	// Readies are combinational and drop while frozen, so nothing is taken unseen
	assign S_AXI_AWREADY_OUT = !s_r.aw_got && CE_IN;
	assign S_AXI_WREADY_OUT = !s_r.w_got && CE_IN;
	assign S_AXI_BRESP_OUT = s_r.bresp;
	assign S_AXI_BVALID_OUT = s_r.bvalid;
	assign S_AXI_ARREADY_OUT = !s_r.rvalid && CE_IN;
	assign S_AXI_RDATA_OUT = s_r.rdata;
	assign S_AXI_RRESP_OUT = s_r.rresp;
	assign S_AXI_RVALID_OUT = s_r.rvalid;
	assign EE_RD_REQ_OUT = s_r.rd_req;
	assign EE_RD_ADDR_OUT = s_r.cur;
	assign SECURE_OUT = s_r.secured;
	assign FLASH_MARGIN_OUT = s_r.fl_mg;
	assign EE_MARGIN_OUT = s_r.ee_mg;

	// Checks run on enabled edges only, since frozen cycles hold
	default clocking cb @(posedge CORE_CLK_IN iff CE_IN); endclocking
	default disable iff (!RSTN_IN);

	// Named steps of a command
	sequence key_reject_s;
		s_r.st == ST_CHECK && opcode == OP_KEY_CHECK && !key_gate_ok;
	endsequence
	sequence key_wrong_s;
		s_r.st == ST_CHECK && opcode == OP_KEY_CHECK && key_gate_ok && !key_match;
	endsequence
	sequence done_err_s;
		s_r.stat[B_DONE] && s_r.stat[B_ACC_ERR] && s_r.st == ST_IDLE;
	endsequence

	launch_starts_a: assert property (launch |=> s_r.st == ST_CHECK
		&& !s_r.stat[B_DONE])
		else $error("launch did not start a command");
	key_refused_a: assert property (key_reject_s |=> done_err_s
		and $stable(s_r.secured))
		else $error("rejected key check changed state");
	key_lockout_a: assert property (key_wrong_s |=> s_r.locked
		&& s_r.secured ##1 s_r.locked[*2])
		else $error("key mismatch did not lock");
	key_open_a: assert property (s_r.st == ST_CHECK && opcode == OP_KEY_CHECK
		&& key_gate_ok && key_match |=> !s_r.secured && s_r.stat[B_DONE])
		else $error("matching keys left device secured");
	margin_bad_a: assert property (s_r.st == ST_CHECK
		&& opcode == OP_SET_MARGIN && !mg_code_ok
		|=> done_err_s and $stable(s_r.fl_mg) and $stable(s_r.ee_mg))
		else $error("bad margin code accepted");
	margin_ee_a: assert property (s_r.st == ST_CHECK
		&& opcode == OP_SET_MARGIN && mg_ok && is_ee
		|=> s_r.ee_mg == $past(param[1:0]) && $stable(s_r.fl_mg))
		else $error("EEPROM margin touched flash level");
	margin_fl_a: assert property (s_r.st == ST_CHECK
		&& opcode == OP_SET_MARGIN && mg_ok && !is_ee
		|=> s_r.fl_mg == s_r.ee_mg && s_r.stat[B_DONE])
		else $error("flash margin not applied to both");
	blank_range_a: assert property (s_r.st == ST_CHECK
		&& opcode == OP_BLANK_CHECK && !range_ok |=> done_err_s)
		else $error("range past block end accepted");
	blank_dirty_a: assert property (s_r.st == ST_BLANK && EE_RD_ACK_IN
		&& EE_RD_DATA_IN != ERASED_BYTE |=> s_r.stat[B_MG1] && s_r.stat[B_MG0])
		else $error("unerased byte not reported");
	viol_kept_a: assert property (s_r.st != ST_IDLE
		|=> $stable(s_r.stat[B_PROT_VIOL]))
		else $error("violation flag changed by command");
	status_reset_a: assert property ($rose(RSTN_IN) |-> s_r.stat == STATUS_RST)
		else $error("status not at reset value");
endmodule

// file: testbench/nsv_ee_model.sv
`timescale 1ns/1ps
// Behavioural EEPROM array behind the blank check read port
module nsv_ee_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic req_in,
	input wire logic [23:0] addr_in,
	input wire logic slow_in,
	input wire logic [23:0] dirty_in,
	input wire logic [23:0] err_in,
	input wire logic [23:0] fatal_in,
	output logic ack_out,
	output logic [7:0] data_out,
	output logic err_out,
	output logic fatal_out
);
	logic gap_r; // Toggles to pace a slow array
	logic go; // A byte is handed over this edge
	// At most every other cycle, so the address has moved before the next byte
	assign go = req_in && !ack_out && !(slow_in && gap_r);
	// Outside an answer the data lines keep changing, never a stale byte
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			gap_r <= 1'b0;
			ack_out <= 1'b0;
			data_out <= 8'h00;
			err_out <= 1'b0;
			fatal_out <= 1'b0;
		end else begin
			gap_r <= !gap_r;
			ack_out <= go;
			data_out <= go ? ((addr_in == dirty_in) ? 8'h5A : 8'hFF) : ~data_out;
			err_out <= go && (addr_in == err_in);
			fatal_out <= go && (addr_in == fatal_in);
		end
	end
endmodule

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import nsv_pkg::*;
	logic clk = 0, rstn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
	logic mode = 1, slow = 0, ack, eerr, efat, awrdy, wrdy, bvalid, arrdy, rvalid, req, sec;
	logic [7:0] awaddr = 0, araddr = 0, edata;
	logic [31:0] wdata = 0, rdata, lastrd, r;
	logic [1:0] backdoor_key_enable_field = 2'h2, bresp, rresp, fm, em;
	logic [63:0] keys = 0;
	logic [23:0] eaddr, dirty = 0, erra = 0, fata = 0;
	logic [63:0] qr[$]; // Expected read data with mask
	logic [1:0] qb[$]; // Expected write responses
	int err_total = 0, n_checks = 0;
	logic ce = 1; // Clock enable, dropped once to show a frozen slave takes nothing
	always #2.5 clk = ~clk;
	nsv_top uut (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce),
		.S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awrdy),
		.S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv),
		.S_AXI_WREADY_OUT(wrdy), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
		.S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arv),
		.S_AXI_ARREADY_OUT(arrdy), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
		.S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .KEY_EN_IN(backdoor_key_enable_field),
		.BACKDOOR_KEYS_IN(keys), .CMD_MODE_OK_IN(mode), .EE_RD_REQ_OUT(req),
		.EE_RD_ADDR_OUT(eaddr), .EE_RD_ACK_IN(ack), .EE_RD_DATA_IN(edata),
		.EE_RD_ERR_IN(eerr), .EE_RD_FATAL_IN(efat), .SECURE_OUT(sec),
		.FLASH_MARGIN_OUT(fm), .EE_MARGIN_OUT(em));
	nsv_ee_model ee (.clk(clk), .rstn(rstn), .req_in(req), .addr_in(eaddr),
		.slow_in(slow), .dirty_in(dirty), .err_in(erra), .fatal_in(fata),
		.ack_out(ack), .data_out(edata), .err_out(eerr), .fatal_out(efat));
	// Pseudo-random source for the stored keys
	function logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Packs a three-slot command: opcode, global address, parameter
	function logic [79:0] op3(input logic [7:0] op, input logic [23:0] a, input logic [15:0] p);
		return {op, a, p, 32'h0};
	endfunction
	task complete_run;
		begin
			$display("checks %0d errors %0d", n_checks, err_total);
			if (err_total == 0 && n_checks > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	// A wait that ran out ends the run
	task hang;
		begin
			err_total++;
			complete_run();
		end
	endtask
	task chk(input logic [31:0] g, input logic [63:0] e);
		begin
			n_checks++;
			if ((g & e[63:32]) !== e[31:0]) begin
				err_total++;
				$display("wrong value at %0t: got %h expected %h", $time, g, e[31:0]);
			end
		end
	endtask
	// Watches both answer channels and compares against the oldest note
	always @(posedge clk) begin
		if (rvalid && rready)
			chk(rdata, qr.pop_front());
		if (bvalid && bready)
			chk({30'h0, bresp}, {32'h3, 30'h0, qb.pop_front()});
	end
	task rst;
		begin
			rstn <= 1'b0;
			repeat (6) @(posedge clk);
			rstn <= 1'b1;
			@(posedge clk);
		end
	endtask
	// Address and data offered together, each released once taken
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		begin
			qb.push_back(e);
			awaddr <= a;
			wdata <= d;
			awv <= 1'b1;
			wv <= 1'b1;
			bready <= 1'b1;
			n = 0;
			do begin
				@(posedge clk);
				if (awrdy) awv <= 1'b0;
				if (wrdy) wv <= 1'b0;
				n++;
			end while (!bvalid && n < 50);
			bready <= 1'b0;
			if (!bvalid) hang();
			// One edge apart, so ready is never lowered and raised at once
			@(posedge clk);
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		int n;
		begin
			qr.push_back({m, e & m});
			araddr <= a;
			arv <= 1'b1;
			rready <= 1'b1;
			n = 0;
			do begin
				@(posedge clk);
				if (arrdy) arv <= 1'b0;
				lastrd = rdata;
				n++;
			end while (!rvalid && n < 50);
			rready <= 1'b0;
			if (!rvalid) hang();
			@(posedge clk);
		end
	endtask
	// Loads the slots, launches, polls for completion, checks status and clears the access error flag
	task cmd(input logic [79:0] s, input int n, input logic [7:0] st);
		int i;
		begin
			for (i = 0; i < n; i++) begin
				wr(OFS_INDEX, i, RESP_OKAY);
				wr(OFS_CMD_HI, {24'h0, s[79-16*i -: 8]}, RESP_OKAY);
				wr(OFS_CMD_LO, {24'h0, s[71-16*i -: 8]}, RESP_OKAY);
			end
			wr(OFS_STATUS, 32'h80, RESP_OKAY);
			lastrd = 0;
			i = 0;
			while (!lastrd[B_DONE] && i < 60) begin
				rd(OFS_STATUS, 0, 0);
				i++;
			end
			if (!lastrd[B_DONE]) hang();
			rd(OFS_STATUS, {24'h0, st}, 32'hFF);
			wr(OFS_STATUS, 32'h20, RESP_OKAY);
		end
	endtask
	initial begin
		rst();
		// Frozen for four edges: the read must wait, then see the reset value
		ce <= 1'b0;
		fork
			rd(OFS_STATUS, {24'h0, STATUS_RST}, 32'hFF);
			begin
				repeat (4) @(posedge clk);
				ce <= 1'b1;
			end
		join
		rd(OFS_MARGIN, 0, 32'hF);
		r = lfsr(32'h3B7F);
		keys <= {r, lfsr(r)};
		wr(8'h40, 0, RESP_SLVERR);
		backdoor_key_enable_field <= 2'h1;
		cmd({16'h0C00, keys}, 5, 8'hA0);
		backdoor_key_enable_field <= KEY_EN_ON;
		cmd({16'h0C00, keys}, 4, 8'hA0);
		cmd({16'h0C00, keys ^ 64'h1}, 5, 8'hA0);
		rd(OFS_SECURITY, 32'h83, 32'hC3);
		chk({31'h0, sec}, {32'h1, 32'h1});
		cmd({16'h0C00, keys}, 5, 8'hA0);
		rst();
		cmd({16'h0C00, keys}, 5, 8'h80);
		rd(OFS_SECURITY, 32'h80, 32'hC3);
		chk({31'h0, sec}, {32'h1, 32'h0});
		cmd(op3(OP_SET_MARGIN, 24'h000100, MG_ERASED), 3, 8'h80);
		rd(OFS_MARGIN, 32'h5, 32'hF);
		cmd(op3(OP_SET_MARGIN, 24'h800010, MG_PROGRAMMED), 3, 8'h80);
		rd(OFS_MARGIN, 32'h9, 32'hF);
		chk({28'h0, em, fm}, {32'hF, 32'h9});
		cmd(op3(OP_SET_MARGIN, 24'h000100, 16'h0003), 3, 8'hA0);
		cmd(op3(OP_SET_MARGIN, 24'h000100, MG_NORMAL), 2, 8'hA0);
		cmd(op3(OP_SET_MARGIN, 24'h400000, MG_NORMAL), 3, 8'hA0);
		mode <= 1'b0;
		cmd(op3(OP_SET_MARGIN, 24'h000100, MG_NORMAL), 3, 8'hA0);
		cmd(op3(OP_BLANK_CHECK, 24'h800000, 16'h2), 3, 8'hA0);
		mode <= 1'b1;
		rd(OFS_MARGIN, 32'h9, 32'hF);
		cmd(op3(OP_SET_MARGIN, 24'h000100, MG_NORMAL), 3, 8'h80);
		rd(OFS_MARGIN, 0, 32'hF);
		// Range ending exactly at the block end, then one byte past it
		cmd(op3(OP_BLANK_CHECK, 24'h8000FE, 16'h2), 3, 8'h80);
		cmd(op3(OP_BLANK_CHECK, 24'h8000FE, 16'h3), 3, 8'hA0);
		cmd(op3(OP_BLANK_CHECK, 24'h800000, 16'h2), 2, 8'hA0);
		cmd(op3(OP_BLANK_CHECK, 24'h000010, 16'h2), 3, 8'hA0);
		cmd(op3(OP_BLANK_CHECK, 24'h800000, 16'h0), 3, 8'h80);
		cmd(op3(8'h3C, 24'h800000, 16'h0), 3, 8'hA0);
		dirty <= 24'h800011;
		slow <= 1'b1;
		cmd(op3(OP_BLANK_CHECK, 24'h800010, 16'h4), 3, 8'h83);
		dirty <= 24'h0;
		erra <= 24'h800021;
		cmd(op3(OP_BLANK_CHECK, 24'h800020, 16'h4), 3, 8'h82);
		erra <= 24'h0;
		fata <= 24'h800031;
		cmd(op3(OP_BLANK_CHECK, 24'h800030, 16'h4), 3, 8'h83);
		complete_run();
	end
endmodule
